// ===== ext_pin_irq_and_debug_cfg.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ext_pin_irq_cfg.svh"

// =====================================================================
// one interrupt input path: synchroniser, filter, trigger detect
module irq_trigger_path
    import ext_pin_irq_pkg::*;
#(
    parameter int FILT_LEN = `FILT_LEN_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selected pin and its setup
    input wire logic pin,
    input wire irq_cfg_s cfg,
    // trigger pulse or level
    output logic trig
);
    localparam int CW = $clog2(FILT_LEN + 1);
    localparam logic [CW-1:0] FILT_LAST = CW'(FILT_LEN - 1);

    logic sync1_q;
    logic sync2_q;
    logic filt_q;
    logic [CW-1:0] filt_cnt_q;
    logic sig;
    logic prev_q;
    logic rise;
    logic fall;

    // =================================================================
    // synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    // =================================================================
    // filter: follows the input once it has held for FILT_LEN cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= 1'b0;
            filt_cnt_q <= '0;
        end else if (sync2_q == filt_q) begin
            filt_cnt_q <= '0;
        end else if (filt_cnt_q == FILT_LAST) begin
            filt_q <= sync2_q;
            filt_cnt_q <= '0;
        end else begin
            filt_cnt_q <= filt_cnt_q + CW'(1);
        end
    end

    assign sig = cfg.filt_en ? filt_q : sync2_q;

    // =================================================================
    // edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sig;
        end
    end

    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;

    always_comb begin
        case (cfg.mode)
            TRIG_OFF: trig = 1'b0;
            TRIG_RISE: trig = rise;
            TRIG_FALL: trig = fall;
            TRIG_BOTH: trig = rise | fall;
            TRIG_HIGH: trig = sig;
            TRIG_LOW: trig = ~sig;
            default: trig = 1'b0;
        endcase
    end
endmodule

// =====================================================================
// top: four external interrupts and debug pin configuration
module ext_pin_irq_and_debug_cfg
    import ext_pin_irq_pkg::*;
#(
    parameter int FILT_LEN = `FILT_LEN_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire port_pins_s port_pins,
    input wire logic ext_interrupt_a,
    input wire logic ext_interrupt_b,
    input wire logic boot_select_pin_n,
    // debug port side
    input wire dbg_status_s dbg_status,
    input wire logic rsvd_hw_we,
    input wire logic rsvd_hw_val,
    output logic debug_port_permit,
    output logic regulator_override_enable,
    // interrupts
    output logic [3:0] irq_pending,
    output logic irq
);
    logic [3:0] pend_q;
    logic [3:0] pend_d;
    logic [3:0] mask_q;
    irq_cfg_s cfg_q [`NUM_IRQ];
    logic [4:0] sel_c_q;
    logic [4:0] sel_d_q;
    logic dbg_dis_q;
    logic regen_q;
    logic rsvd_q;
    logic boot_done_q;
    logic boot_low_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata;
    logic hit;
    logic setup;
    logic wr;
    logic [3:0] trig;
    logic [3:0] src;
    logic [`PIN_COUNT-1:0] all_pins;
    logic wr_pend;
    logic wr_mask;
    logic wr_dbg;
    logic wr_sel_c;
    logic wr_sel_d;
    logic [`NUM_IRQ-1:0] wr_cfg;

    // =================================================================
    // pin selection for C and D
    assign all_pins = port_pins;

    function automatic logic pick(input logic [4:0] code,
                                  input logic [`PIN_COUNT-1:0] pins);
        // codes past the last pin read as a constant low
        if (code < 5'(`PIN_COUNT)) begin
            pick = pins[code];
        end else begin
            pick = 1'b0;
        end
    endfunction

    assign src[0] = ext_interrupt_a;
    assign src[1] = ext_interrupt_b;
    assign src[2] = pick(sel_c_q, all_pins);
    assign src[3] = pick(sel_d_q, all_pins);

    for (genvar i = 0; i < `NUM_IRQ; i++) begin : g_path
        irq_trigger_path #(
            .FILT_LEN(FILT_LEN)
        ) u_path (
            .pclk(pclk),
            .presetn(presetn),
            .pin(src[i]),
            .cfg(cfg_q[i]),
            .trig(trig[i])
        );
    end

    // =================================================================
    // apb decode
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;

    // =================================================================
    // write strobes: paddr is compared in full, no aliasing
    assign wr_pend = wr && (paddr == `ADDR_PENDING);
    assign wr_mask = wr && (paddr == `ADDR_IRQ_MASK);
    assign wr_dbg = wr && (paddr == `ADDR_DBG_CFG);
    assign wr_sel_c = wr && (paddr == `ADDR_SEL_C);
    assign wr_sel_d = wr && (paddr == `ADDR_SEL_D);
    assign wr_cfg[0] = wr && (paddr == `ADDR_CFG_A);
    assign wr_cfg[1] = wr && (paddr == `ADDR_CFG_B);
    assign wr_cfg[2] = wr && (paddr == `ADDR_CFG_C);
    assign wr_cfg[3] = wr && (paddr == `ADDR_CFG_D);

    // unused bits read as zero; the reserved bit reads back its stored value
    always_comb begin
        rdata = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `ADDR_PENDING: rdata[3:0] = pend_q;
            `ADDR_IRQ_MASK: rdata[3:0] = mask_q;
            `ADDR_CFG_A: begin
                rdata[`CFG_FILT_BIT] = cfg_q[0].filt_en;
                rdata[`CFG_MODE_HI:`CFG_MODE_LO] = cfg_q[0].mode;
            end
            `ADDR_CFG_B: begin
                rdata[`CFG_FILT_BIT] = cfg_q[1].filt_en;
                rdata[`CFG_MODE_HI:`CFG_MODE_LO] = cfg_q[1].mode;
            end
            `ADDR_CFG_C: begin
                rdata[`CFG_FILT_BIT] = cfg_q[2].filt_en;
                rdata[`CFG_MODE_HI:`CFG_MODE_LO] = cfg_q[2].mode;
            end
            `ADDR_CFG_D: begin
                rdata[`CFG_FILT_BIT] = cfg_q[3].filt_en;
                rdata[`CFG_MODE_HI:`CFG_MODE_LO] = cfg_q[3].mode;
            end
            `ADDR_DBG_CFG: begin
                rdata[`DBG_DIS_BIT] = dbg_dis_q;
                rdata[`DBG_REGEN_BIT] = regen_q;
                rdata[`DBG_RSVD_BIT] = rsvd_q;
            end
            `ADDR_DBG_STATE: begin
                rdata[`ST_BOOT_BIT] = boot_low_q;
                rdata[`ST_FORCED_BIT] = dbg_status.forced;
                rdata[`ST_SWEN_BIT] = dbg_status.swen;
            end
            `ADDR_SEL_C: rdata[`SEL_HI:0] = sel_c_q;
            `ADDR_SEL_D: rdata[`SEL_HI:0] = sel_d_q;
            default: hit = 1'b0;
        endcase
    end

    // read data is captured at the end of the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata_q <= rdata;
        end
    end

    // =================================================================
    // trigger configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `NUM_IRQ; i++) begin
                cfg_q[i] <= '{filt_en: 1'b0, mode: TRIG_OFF};
            end
        end else begin
            for (int i = 0; i < `NUM_IRQ; i++) begin
                if (wr_cfg[i]) begin
                    cfg_q[i].filt_en <= pwdata[`CFG_FILT_BIT];
                    cfg_q[i].mode <= trig_mode_e'(
                        pwdata[`CFG_MODE_HI:`CFG_MODE_LO]);
                end
            end
        end
    end

    // =================================================================
    // pin selectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_c_q <= `SEL_C_RST;
        end else if (wr_sel_c) begin
            sel_c_q <= pwdata[`SEL_HI:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_d_q <= `SEL_D_RST;
        end else if (wr_sel_d) begin
            sel_d_q <= pwdata[`SEL_HI:0];
        end
    end

    // =================================================================
    // pending flags: a trigger in the clearing cycle wins
    always_comb begin
        pend_d = pend_q;
        if (wr_pend) begin
            pend_d = pend_q & ~pwdata[3:0];
        end
        pend_d = pend_d | trig;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 4'h0;
        end else if (wr_mask) begin
            mask_q <= pwdata[3:0];
        end
    end

    assign irq_pending = pend_q;
    assign irq = |(pend_q & mask_q);

    // =================================================================
    // debug configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_dis_q <= 1'b0;
        end else if (wr_dbg) begin
            dbg_dis_q <= pwdata[`DBG_DIS_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regen_q <= `REGEN_RST;
        end else if (wr_dbg) begin
            regen_q <= pwdata[`DBG_REGEN_BIT];
        end
    end

    // hardware may change the reserved bit and takes priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_q <= 1'b0;
        end else if (rsvd_hw_we) begin
            rsvd_q <= rsvd_hw_val;
        end else if (wr_dbg) begin
            rsvd_q <= pwdata[`DBG_RSVD_BIT];
        end
    end

    // a debug port that is already active keeps its pins
    assign debug_port_permit = ~dbg_dis_q | dbg_status.active;
    assign regulator_override_enable = regen_q;

    // =================================================================
    // boot pin caught on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_done_q <= 1'b0;
            boot_low_q <= 1'b0;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            boot_low_q <= ~boot_select_pin_n;
        end
    end
endmodule
`default_nettype wire

// ===== ext_pin_irq_cfg.svh
`ifndef EXT_PIN_IRQ_CFG_SVH
`define EXT_PIN_IRQ_CFG_SVH
// =====================================================================
// register byte addresses
`define ADDR_PENDING 32'h4000A814
`define ADDR_IRQ_MASK 32'h4000A854
`define ADDR_CFG_A 32'h4000A860
`define ADDR_CFG_B 32'h4000A864
`define ADDR_CFG_C 32'h4000A868
`define ADDR_CFG_D 32'h4000A86C
`define ADDR_DBG_CFG 32'h4000BC00
`define ADDR_DBG_STATE 32'h4000BC04
`define ADDR_SEL_C 32'h4000BC14
`define ADDR_SEL_D 32'h4000BC18
// =====================================================================
// field positions
`define CFG_FILT_BIT 8
`define CFG_MODE_HI 7
`define CFG_MODE_LO 5
`define SEL_HI 4
`define DBG_DIS_BIT 5
`define DBG_REGEN_BIT 4
`define DBG_RSVD_BIT 3
`define ST_BOOT_BIT 3
`define ST_FORCED_BIT 1
`define ST_SWEN_BIT 0
// =====================================================================
// reset values and counts
`define SEL_C_RST 5'h0F
`define SEL_D_RST 5'h10
`define REGEN_RST 1'b1
`define PIN_COUNT 24
`define NUM_IRQ 4
`define FILT_LEN_DEF 4
`endif

// ===== ext_pin_irq_pkg.sv
package ext_pin_irq_pkg;
    typedef enum logic [2:0] {
        TRIG_OFF = 3'b000,
        TRIG_RISE = 3'b001,
        TRIG_FALL = 3'b010,
        TRIG_BOTH = 3'b011,
        TRIG_HIGH = 3'b100,
        TRIG_LOW = 3'b101
    } trig_mode_e;

    typedef struct packed {
        logic filt_en;
        trig_mode_e mode;
    } irq_cfg_s;

    typedef struct packed {
        logic [7:0] pc;
        logic [7:0] pb;
        logic [7:0] pa;
    } port_pins_s;

    typedef struct packed {
        logic active;
        logic forced;
        logic swen;
    } dbg_status_s;
endpackage

// ===== ext_pin_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_pin_irq_cfg.svh"
module ext_pin_irq_asserts
    import ext_pin_irq_pkg::*;
#(
    parameter int FILT_LEN = `FILT_LEN_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // debug and interrupts
    input wire dbg_status_s dbg_status,
    input wire logic debug_port_permit,
    input wire logic regulator_override_enable,
    input wire logic [3:0] irq_pending,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    logic [3:0] clr;
    assign acc = psel && penable;
    assign mapped = paddr inside {`ADDR_PENDING, `ADDR_IRQ_MASK, `ADDR_CFG_A,
        `ADDR_CFG_B, `ADDR_CFG_C, `ADDR_CFG_D, `ADDR_DBG_CFG, `ADDR_DBG_STATE,
        `ADDR_SEL_C, `ADDR_SEL_D};
    assign clr = (acc && pwrite && paddr == `ADDR_PENDING) ?
        pwdata[3:0] : 4'h0;
    sequence wr_dbg_s;
        acc && pwrite && paddr == `ADDR_DBG_CFG;
    endsequence
    sequence rd_s(logic [31:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    ready_high_a: assert property (acc |-> pready)
        else $error("no ready in access phase");
    bad_addr_a: assert property (acc && !mapped |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    good_addr_a: assert property (!(acc && !mapped) |-> !pslverr)
        else $error("error flag without cause");
    pend_hold_a: assert property (
        (~irq_pending & $past(irq_pending) & ~$past(clr)) == 4'h0)
        else $error("pending flag cleared without a write of one");
    pend_read_a: assert property (
        rd_s(`ADDR_PENDING) |-> prdata == {28'h0, $past(irq_pending)})
        else $error("pending read mismatch");
    state_read_a: assert property (
        rd_s(`ADDR_DBG_STATE) |-> prdata[1:0] ==
        $past({dbg_status.forced, dbg_status.swen}))
        else $error("debug state read mismatch");
    regen_write_a: assert property (
        wr_dbg_s |=> regulator_override_enable == $past(pwdata[4]))
        else $error("regulator override not written");
    dbg_block_a: assert property (
        wr_dbg_s ##1 !dbg_status.active |->
        debug_port_permit == !$past(pwdata[5]))
        else $error("debug permit wrong after write");
    dbg_active_a: assert property (dbg_status.active |-> debug_port_permit)
        else $error("active debug port blocked");
    irq_cause_a: assert property (irq |-> irq_pending != 4'h0)
        else $error("interrupt without pending flag");
endmodule
bind ext_pin_irq_and_debug_cfg ext_pin_irq_asserts #(.FILT_LEN(FILT_LEN))
    u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dbg_status, .debug_port_permit,
    .regulator_override_enable, .irq_pending, .irq);
`default_nettype wire

// ===== board_pins.sv
`timescale 1ns/1ps
`default_nettype none
module board_pins
    import ext_pin_irq_pkg::*;
(
    // clock
    input wire logic pclk,
    // levels asked for by the bench
    input wire port_pins_s pins_cmd,
    input wire logic [1:0] ab_cmd,
    input wire logic boot_n_cmd,
    input wire dbg_status_s dbg_cmd,
    // levels seen at the device pins
    output port_pins_s port_pins = '0,
    output logic ext_interrupt_a = 1'b0,
    output logic ext_interrupt_b = 1'b0,
    output logic boot_select_pin_n = 1'b0,
    output dbg_status_s dbg_status = '0
);
    // board drivers switch just after an edge, never at it
    always @(posedge pclk) begin
        port_pins <= pins_cmd;
        {ext_interrupt_b, ext_interrupt_a} <= ab_cmd;
        boot_select_pin_n <= boot_n_cmd;
        dbg_status <= dbg_cmd;
    end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_pin_irq_cfg.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module testbench
    import ext_pin_irq_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, debug_port_permit, regulator_override_enable;
    logic irq, ext_interrupt_a, ext_interrupt_b, boot_select_pin_n;
    logic [3:0] irq_pending;
    logic rsvd_hw_we = 1'b0, rsvd_hw_val = 1'b0, boot_n_cmd = 1'b0;
    logic [1:0] ab_cmd = 2'h0;
    port_pins_s pins_cmd = '0, port_pins;
    dbg_status_s dbg_cmd = '0, dbg_status;
    int n_fail = 0, tests_run = 0;
    localparam logic [31:0] RADDR [10] = '{`ADDR_PENDING, `ADDR_IRQ_MASK,
        `ADDR_CFG_A, `ADDR_CFG_B, `ADDR_CFG_C, `ADDR_CFG_D, `ADDR_DBG_CFG,
        `ADDR_DBG_STATE, `ADDR_SEL_C, `ADDR_SEL_D};
    localparam logic [31:0] RVAL [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h10, 32'h8, 32'hF, 32'h10};
    localparam logic STEP [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    always #2 pclk = ~pclk;
    board_pins u_board_pins (.pclk, .pins_cmd, .ab_cmd, .boot_n_cmd,
        .dbg_cmd, .port_pins, .ext_interrupt_a, .ext_interrupt_b,
        .boot_select_pin_n, .dbg_status);
    ext_pin_irq_and_debug_cfg #(.FILT_LEN(2)) u_ext_pin_irq_and_debug_cfg (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_pins, .ext_interrupt_a, .ext_interrupt_b,
        .boot_select_pin_n, .dbg_status, .rsvd_hw_we, .rsvd_hw_val,
        .debug_port_permit, .regulator_override_enable, .irq_pending, .irq);
    // =================================================================
    // bus and helpers
    task automatic apb(input logic wr, input logic [31:0] a, d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic hit(input int m, input logic o, n);
        return (m == 1 && !o && n) || (m == 2 && o && !n) ||
            (m == 3 && o != n) || (m == 4 && (o || n)) ||
            (m == 5 && (!o || !n));
    endfunction
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        idle(20000);
        n_fail++;
        conclude();
    end
    // =================================================================
    // tests
    initial begin
        logic old;
        idle(16);
        presetn <= 1'b1;
        @(posedge pclk);
        boot_n_cmd <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, RADDR[i], 32'h0);
            `CHK("reset value", RVAL[i], q)
        end
        apb(1'b0, 32'h4000A800, 32'h0);
        `CHK("unmapped error", 1'b1, e)
        dbg_cmd <= 3'b011;
        apb(1'b1, `ADDR_DBG_STATE, 32'hFFFFFFFF);
        apb(1'b0, `ADDR_DBG_STATE, 32'h0);
        `CHK("debug state", 32'hB, q)
        apb(1'b0, `ADDR_DBG_CFG, 32'h0);
        apb(1'b1, `ADDR_DBG_CFG, (q & 32'h8) | 32'h20);
        `CHK("regulator off", 1'b0, regulator_override_enable)
        `CHK("debug blocked", 1'b0, debug_port_permit)
        dbg_cmd <= 3'b111;
        idle(2);
        `CHK("debug kept", 1'b1, debug_port_permit)
        rsvd_hw_val <= 1'b1;
        rsvd_hw_we <= 1'b1;
        @(posedge pclk);
        rsvd_hw_we <= 1'b0;
        apb(1'b0, `ADDR_DBG_CFG, 32'h0);
        `CHK("hw reserved bit", 32'h28, q)
        apb(1'b1, `ADDR_DBG_CFG, (q & 32'h8) | 32'h10);
        `CHK("regulator on", 1'b1, regulator_override_enable)
        apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, `ADDR_CFG_B, 32'h20);
        ab_cmd <= 2'b10;
        idle(8);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `ADDR_CFG_A, 32'(m) << 5);
            old = 1'b0;
            for (int s = 0; s < 4; s++) begin
                apb(1'b1, `ADDR_PENDING, 32'h1);
                ab_cmd[0] <= STEP[s];
                idle(8);
                `CHK("a flag", hit(m, old, STEP[s]), irq_pending[0])
                `CHK("irq line", hit(m, old, STEP[s]), irq)
                apb(1'b0, `ADDR_PENDING, 32'h0);
                `CHK("b kept", 1'b1, q[1])
                old = STEP[s];
            end
        end
        `CHK("b masked", 1'b0, irq)
        apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
        `CHK("b unmasked", 1'b1, irq)
        apb(1'b1, `ADDR_PENDING, 32'h2);
        `CHK("b cleared", 4'h0, irq_pending)
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `ADDR_CFG_A, {23'h0, f[0], 8'h20});
            apb(1'b1, `ADDR_PENDING, 32'hF);
            ab_cmd[0] <= 1'b1;
            @(posedge pclk);
            ab_cmd[0] <= 1'b0;
            idle(10);
            `CHK("glitch", !f[0], irq_pending[0])
            apb(1'b1, `ADDR_PENDING, 32'h1);
            ab_cmd[0] <= 1'b1;
            idle(10);
            `CHK("steady", 1'b1, irq_pending[0])
            ab_cmd[0] <= 1'b0;
            idle(4);
        end
        apb(1'b1, `ADDR_CFG_C, 32'h80);
        apb(1'b1, `ADDR_CFG_D, 32'h80);
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, `ADDR_SEL_C, 32'(c));
            apb(1'b1, `ADDR_SEL_D, 32'(c));
            pins_cmd <= 24'h1 << c;
            idle(6);
            apb(1'b1, `ADDR_PENDING, 32'hC);
            idle(6);
            `CHK("c d flags", {2{c < 24}}, irq_pending[3:2])
            apb(1'b0, `ADDR_SEL_D, 32'h0);
            `CHK("select read", 32'(c), q)
        end
        conclude();
    end
endmodule
`default_nettype wire
